// ==== hdl/dha_adapter.sv ====
`timescale 1ns/1ps
// Operation
// R1 - Start of operation blocks other host, timeout
// R2 - Blocked host cannot select nor read status
// R3 - Grants alternate between hosts on demand
// R4 - Seek from waiting host held until free
// R5 - Transfer complete releases ownership at once
// R6 - Each host keeps its last status word
// R7 - Timeout counts from drive seek start
// R8 - Positioning complete flag plus interrupt, then status
// R9 - Host seeks before every transfer
// R10 - Host recalibrates, dummy reads after seek error
// R11 - Host abandons drive after repeated seek errors
// R12 - Fixed-head use: same order, alternate on conflict
// R13 - Timeout grants waiting host next cycle
module dha_adapter #(
  parameter int TIMEOUT_CYC = dha_pkg::LOCK_CYC
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Host channels
  dha_if.adapter                         h0,
  dha_if.adapter                         h1,
  // Disc subsystem
  output logic                           drv_cmd,
  output logic [1:0]                     drv_op,
  output logic [dha_pkg::DRV_W-1:0]      drv_unit,
  output logic [dha_pkg::CYL_W-1:0]      drv_cyl,
  input  wire logic                      drv_seek_begin,
  input  wire logic                      drv_seek_done,
  input  wire logic                      drv_xfer_done,
  input  wire logic [7:0]                drv_status
);

  // =====================================================================
  // Types
  typedef enum logic [2:0] {
    A_IDLE  = 3'b000,  // Free, accepts either host
    A_START = 3'b001,  // Seek issued, waiting for drive to move
    A_POS   = 3'b010,  // Heads moving
    A_READY = 3'b011,  // Positioned, owner may transfer
    A_XFER  = 3'b100   // Sector transfer running
  } dha_ast_t;

  typedef struct packed {
    dha_ast_t                      st;        // Arbiter state
    logic                          owner;     // Host holding the adapter
    logic                          last;      // Host granted last
    logic                          tmr_on;    // Timeout running
    logic [dha_pkg::TMR_W-1:0]     tmr;       // Timeout counter
    logic [1:0]                    accept;    // Command accept pulses
    logic [1:0]                    seek_done; // Positioning complete flags
    logic [1:0]                    xfer_done; // Transfer complete flags
    logic [1:0]                    irq;       // Interrupt pulses
    logic [1:0][7:0]               status;    // Status word per host
    logic [1:0]                    sval;      // Status valid per host
    logic [1:0]                    lock;      // Lockout per host
    logic                          drv_cmd;   // Drive command pulse
    logic [1:0]                    drv_op;    // Drive command code
    logic [dha_pkg::DRV_W-1:0]     drv_unit;  // Selected drive
    logic [dha_pkg::CYL_W-1:0]     drv_cyl;   // Target cylinder
  } dha_astate_t;

  localparam logic [dha_pkg::TMR_W-1:0] TMR_LAST = (dha_pkg::TMR_W)'(TIMEOUT_CYC - 1);

  // =====================================================================
  // Decode helpers
  // True for the two data transfer commands
  function automatic logic is_xfer(input logic [1:0] op);
    is_xfer = (op == dha_pkg::OP_READ) || (op == dha_pkg::OP_WRITE);
  endfunction

  // =====================================================================
  // State
  dha_astate_t s;       // Registered state
  dha_astate_t next_s;  // Next state

  // Host channel inputs gathered into arrays
  logic [1:0]                      vld;
  logic [1:0][1:0]                 op;
  logic [1:0][dha_pkg::DRV_W-1:0]  unit;
  logic [1:0][dha_pkg::CYL_W-1:0]  cyl;

  assign vld  = {h1.cmd_valid, h0.cmd_valid};
  assign op   = {h1.cmd_op, h0.cmd_op};
  assign unit = {h1.cmd_drive, h0.cmd_drive};
  assign cyl  = {h1.cmd_cyl, h0.cmd_cyl};

  // =====================================================================
  // Next state logic
  always_comb begin
    logic g;        // Host chosen for a grant
    logic timeout;  // Ownership time used up
    g       = 1'b0;
    timeout = 1'b0;
    next_s  = s;
    // Pulses last one cycle
    next_s.accept  = 2'b00;
    next_s.irq     = 2'b00;
    next_s.drv_cmd = 1'b0;
    // Timeout counter
    if (s.tmr_on) begin
      next_s.tmr = s.tmr + 1'b1;
      timeout    = (s.tmr == TMR_LAST);  // [R1]
    end
    case (s.st)
      A_IDLE: begin
        // Conflicting hosts take turns, a lone host is served at once
        if (vld == 2'b11) begin
          g = ~s.last;  // [R3] [R12]
        end else begin
          g = vld[1];
        end
        if (vld != 2'b00) begin
          next_s.owner        = g;
          next_s.last         = g;
          next_s.accept[g]    = 1'b1;
          next_s.lock[~g]     = 1'b1;  // [R1]
          next_s.lock[g]      = 1'b0;
          next_s.sval[~g]     = 1'b0;  // [R2]
          next_s.sval[g]      = 1'b0;
          next_s.seek_done[g] = 1'b0;
          next_s.xfer_done[g] = 1'b0;
          next_s.drv_cmd      = 1'b1;
          next_s.drv_op       = op[g];
          next_s.drv_unit     = unit[g];
          next_s.drv_cyl      = cyl[g];
          if (is_xfer(op[g])) begin
            // Transfer without a seek still runs under the timeout
            next_s.tmr    = '0;
            next_s.tmr_on = 1'b1;
            next_s.st     = A_XFER;
          end else begin
            next_s.st = A_START;
          end
        end
      end
      A_START: begin
        // Timeout measured from the moment the drive starts moving
        if (drv_seek_begin) begin
          if (!s.tmr_on) begin
            next_s.tmr    = '0;  // [R7] [R13]
            next_s.tmr_on = 1'b1;
          end
          next_s.st = A_POS;
        end
      end
      A_POS: begin
        // Positioning complete: flag, interrupt, status now valid
        if (drv_seek_done) begin
          next_s.seek_done[s.owner] = 1'b1;  // [R8]
          next_s.irq[s.owner]       = 1'b1;
          next_s.status[s.owner]    = drv_status;
          next_s.sval[s.owner]      = 1'b1;
          next_s.st                 = A_READY;
        end
      end
      A_READY: begin
        // Owner transfers or seeks again; the other host keeps waiting
        if (vld[s.owner]) begin
          next_s.accept[s.owner]    = 1'b1;
          next_s.seek_done[s.owner] = 1'b0;
          next_s.drv_cmd            = 1'b1;
          next_s.drv_op             = op[s.owner];
          next_s.drv_unit           = unit[s.owner];
          next_s.drv_cyl            = cyl[s.owner];
          if (is_xfer(op[s.owner])) begin
            next_s.st = A_XFER;
          end else begin
            next_s.st = A_START;
          end
        end
      end
      A_XFER: begin
        // Transfer complete frees the adapter for either host
        if (drv_xfer_done) begin
          next_s.xfer_done[s.owner] = 1'b1;
          next_s.irq[s.owner]       = 1'b1;
          next_s.status[s.owner]    = drv_status;  // [R6]
          next_s.sval[s.owner]      = 1'b1;
          next_s.tmr_on             = 1'b0;
          next_s.lock               = 2'b00;  // [R5]
          next_s.st                 = A_IDLE;
        end
      end
      default: begin
        next_s.st = A_IDLE;
      end
    endcase
    // Expired ownership: waiting host is granted from idle next cycle
    if (timeout && (s.st != A_IDLE)) begin
      next_s.tmr_on = 1'b0;  // [R1] [R13]
      next_s.lock   = 2'b00;
      next_s.st     = A_IDLE;
    end
    // A waiting host's seek simply stays pending on its channel
    if ((s.st != A_IDLE) && vld[~s.owner]) begin
      next_s.accept[~s.owner] = 1'b0;  // [R4] [R2]
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: A_IDLE, owner: 1'b0, last: 1'b1, tmr_on: 1'b0, tmr: '0,
             accept: 2'b00, seek_done: 2'b00, xfer_done: 2'b00, irq: 2'b00,
             status: {dha_pkg::ST_RESET, dha_pkg::ST_RESET}, sval: 2'b00,
             lock: 2'b00, drv_cmd: 1'b0, drv_op: dha_pkg::OP_SEEK,
             drv_unit: '0, drv_cyl: '0};
    end else begin
      s <= next_s;
    end
  end

  // =====================================================================
  // Outputs, all from the state register
  assign h0.cmd_accept   = s.accept[0];
  assign h0.seek_done    = s.seek_done[0];
  assign h0.xfer_done    = s.xfer_done[0];
  assign h0.irq          = s.irq[0];
  assign h0.status       = s.status[0];
  assign h0.status_valid = s.sval[0];
  assign h0.locked_out   = s.lock[0];
  assign h1.cmd_accept   = s.accept[1];
  assign h1.seek_done    = s.seek_done[1];
  assign h1.xfer_done    = s.xfer_done[1];
  assign h1.irq          = s.irq[1];
  assign h1.status       = s.status[1];
  assign h1.status_valid = s.sval[1];
  assign h1.locked_out   = s.lock[1];
  assign drv_cmd         = s.drv_cmd;
  assign drv_op          = s.drv_op;
  assign drv_unit        = s.drv_unit;
  assign drv_cyl         = s.drv_cyl;

endmodule

// ==== hdl/dha_host.sv ====
`timescale 1ns/1ps
// =====================================================================
// Host end: runs one sector request with seek and error recovery
module dha_host (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Adapter channel
  dha_if.host                            bus,
  // User request
  input  wire logic                      usr_req,
  input  wire logic                      usr_write,
  input  wire logic [dha_pkg::DRV_W-1:0] usr_drive,
  input  wire logic [dha_pkg::CYL_W-1:0] usr_cyl,
  // User answer
  output logic                           usr_busy,
  output logic                           usr_done,
  output logic                           usr_err,
  output logic [7:0]                     usr_status
);

  // =====================================================================
  // Types
  typedef enum logic [3:0] {
    H_IDLE   = 4'b0000,  // Waiting for a user request
    H_SEEK   = 4'b0001,  // Seek offered
    H_SWAIT  = 4'b0010,  // Waiting for positioning complete
    H_RW     = 4'b0011,  // Transfer offered
    H_RWAIT  = 4'b0100,  // Waiting for transfer complete
    H_RECAL  = 4'b0101,  // Recalibrate offered
    H_RCWAIT = 4'b0110,  // Waiting for recalibrate
    H_DUMMY  = 4'b0111,  // Dummy read offered
    H_DWAIT  = 4'b1000   // Waiting for dummy read
  } dha_hst_t;

  typedef struct packed {
    dha_hst_t                    st;     // Host state
    logic                        wr;     // Request is a write
    logic [dha_pkg::DRV_W-1:0]   drive;  // Requested drive
    logic [dha_pkg::CYL_W-1:0]   cyl;    // Requested cylinder
    logic [1:0]                  tries;  // Recalibrations so far
    logic [3:0]                  dead;   // Drives given up on
    logic                        valid;  // Command offered
    logic [1:0]                  op;     // Command code
    logic [dha_pkg::CYL_W-1:0]   ccyl;   // Command cylinder
    logic                        busy;   // Request running
    logic                        done;   // Completion pulse
    logic                        err;    // Request failed
    logic [7:0]                  stat;   // Last status word
  } dha_hstate_t;

  localparam logic [1:0] TRY_LAST = 2'(dha_pkg::MAX_RECAL);

  dha_hstate_t s;       // Registered state
  dha_hstate_t next_s;  // Next state

  // =====================================================================
  // Next state logic
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    // Withdraw an offered command once taken
    if (bus.cmd_accept) begin
      next_s.valid = 1'b0;
    end
    case (s.st)
      H_IDLE: begin
        if (usr_req) begin
          next_s.drive = usr_drive;
          next_s.wr    = usr_write;
          next_s.cyl   = usr_cyl;
          next_s.tries = 2'h0;
          if (s.dead[usr_drive]) begin
            next_s.done = 1'b1;  // [R11]
            next_s.err  = 1'b1;
          end else begin
            next_s.busy  = 1'b1;
            next_s.valid = 1'b1;  // [R9]
            next_s.op    = dha_pkg::OP_SEEK;
            next_s.ccyl  = usr_cyl;
            next_s.st    = H_SEEK;
          end
        end
      end
      H_SEEK:  if (bus.cmd_accept) next_s.st = H_SWAIT;
      H_SWAIT: begin
        if (bus.seek_done && bus.status_valid) begin
          next_s.stat = bus.status;
          if (bus.status[dha_pkg::ST_LOC]) begin
            next_s.tries = s.tries + 2'h1;  // [R10]
            next_s.valid = 1'b1;
            next_s.op    = dha_pkg::OP_RECAL;
            next_s.ccyl  = dha_pkg::DUMMY_CYL;
            next_s.st    = H_RECAL;
          end else begin
            next_s.valid = 1'b1;
            next_s.op    = s.wr ? dha_pkg::OP_WRITE : dha_pkg::OP_READ;
            next_s.ccyl  = s.cyl;
            next_s.st    = H_RW;
          end
        end
      end
      H_RW:     if (bus.cmd_accept) next_s.st = H_RWAIT;
      H_RWAIT: begin
        if (bus.xfer_done) begin
          next_s.stat = bus.status;
          next_s.err  = bus.status[dha_pkg::ST_ERR];
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.st   = H_IDLE;
        end
      end
      H_RECAL:  if (bus.cmd_accept) next_s.st = H_RCWAIT;
      H_RCWAIT: begin
        // One sector from cylinder 0 into scratch frees the adapter
        if (bus.seek_done) begin
          next_s.valid = 1'b1;  // [R10]
          next_s.op    = dha_pkg::OP_READ;
          next_s.ccyl  = dha_pkg::DUMMY_CYL;
          next_s.st    = H_DUMMY;
        end
      end
      H_DUMMY:  if (bus.cmd_accept) next_s.st = H_DWAIT;
      H_DWAIT: begin
        if (bus.xfer_done) begin
          if (s.tries == TRY_LAST) begin
            next_s.dead[s.drive] = 1'b1;  // [R11]
            next_s.err           = 1'b1;
            next_s.busy          = 1'b0;
            next_s.done          = 1'b1;
            next_s.st            = H_IDLE;
          end else begin
            next_s.valid = 1'b1;  // [R9]
            next_s.op    = dha_pkg::OP_SEEK;
            next_s.ccyl  = s.cyl;
            next_s.st    = H_SEEK;
          end
        end
      end
      default: next_s.st = H_IDLE;
    endcase
  end

  // =====================================================================
  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: H_IDLE, wr: 1'b0, drive: '0, cyl: '0, tries: 2'h0, dead: 4'h0,
             valid: 1'b0, op: dha_pkg::OP_SEEK, ccyl: '0, busy: 1'b0,
             done: 1'b0, err: 1'b0, stat: dha_pkg::ST_RESET};
    end else begin
      s <= next_s;
    end
  end

  // =====================================================================
  // Outputs
  assign bus.cmd_valid = s.valid;
  assign bus.cmd_op    = s.op;
  assign bus.cmd_drive = s.drive;
  assign bus.cmd_cyl   = s.ccyl;
  assign usr_busy      = s.busy;
  assign usr_done      = s.done;
  assign usr_err       = s.err;
  assign usr_status    = s.stat;

endmodule

// ==== hdl/dha_if.sv ====
`timescale 1ns/1ps
// =====================================================================
// One host channel between a host processor and the shared adapter
interface dha_if;
  logic                        cmd_valid;    // Host holds a command
  logic [1:0]                  cmd_op;       // Command code
  logic [dha_pkg::DRV_W-1:0]   cmd_drive;    // Drive unit
  logic [dha_pkg::CYL_W-1:0]   cmd_cyl;      // Cylinder
  logic                        cmd_accept;   // Adapter took the command
  logic                        seek_done;    // Positioning complete flag
  logic                        xfer_done;    // Transfer complete flag
  logic                        irq;          // Program interrupt pulse
  logic [7:0]                  status;       // Status word
  logic                        status_valid; // Status word may be used
  logic                        locked_out;   // Host is blocked

  // Adapter end
  modport adapter (
    input  cmd_valid, cmd_op, cmd_drive, cmd_cyl,
    output cmd_accept, seek_done, xfer_done, irq, status, status_valid, locked_out
  );

  // Host end
  modport host (
    output cmd_valid, cmd_op, cmd_drive, cmd_cyl,
    input  cmd_accept, seek_done, xfer_done, irq, status, status_valid, locked_out
  );
endinterface

// ==== hdl/dha_pkg.sv ====
// =====================================================================
// Shared constants for the dual host disc access arbiter
package dha_pkg;

  // =====================================================================
  // Command codes carried from a host to the adapter
  localparam logic [1:0] OP_SEEK  = 2'h0;  // Position heads on a cylinder
  localparam logic [1:0] OP_RECAL = 2'h1;  // Return heads to cylinder 0
  localparam logic [1:0] OP_READ  = 2'h2;  // Read one sector
  localparam logic [1:0] OP_WRITE = 2'h3;  // Write one sector

  // =====================================================================
  // Status word bit positions, kept per host
  localparam int ST_ERR  = 0;  // Any error
  localparam int ST_OVR  = 1;  // Channel overrun
  localparam int ST_CHK  = 2;  // Checkword mismatch
  localparam int ST_LOC  = 3;  // Location (seek) error
  localparam int ST_END  = 4;  // End error
  localparam int ST_SEC  = 5;  // Sector error
  localparam int ST_HEAD = 6;  // Head error
  localparam int ST_BAD  = 7;  // Defective sector
  localparam logic [7:0] ST_RESET = 8'h00;  // Status after reset

  // =====================================================================
  // Field widths
  localparam int DRV_W = 2;   // Drive unit number
  localparam int CYL_W = 10;  // Cylinder number

  // =====================================================================
  // Timing
  localparam int CLK_MHZ  = 100;   // System clock rate
  localparam int LOCK_MS  = 6000;  // Ownership timeout, six seconds
  localparam int LOCK_CYC = LOCK_MS * 1000 * CLK_MHZ;  // Timeout in clocks
  localparam int TMR_W    = 30;    // Timeout counter width

  // =====================================================================
  // Host recovery
  localparam int         MAX_RECAL  = 3;      // Recalibrations before giving up
  localparam logic [9:0] DUMMY_CYL  = 10'h000; // Cylinder of the dummy read
  localparam int         SECTOR_WDS = 256;    // Words moved by one read

endpackage

// ==== verif/dha_checker.sv ====
`timescale 1ns/1ps
// =====================================================================
// Watches both host channels of the adapter
module dha_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Host 0 channel
  input wire logic       h0_cmd_valid,
  input wire logic       h0_cmd_accept,
  input wire logic       h0_seek_done,
  input wire logic       h0_xfer_done,
  input wire logic       h0_irq,
  input wire logic [7:0] h0_status,
  input wire logic       h0_status_valid,
  input wire logic       h0_locked_out,
  // Host 1 channel
  input wire logic       h1_cmd_valid,
  input wire logic       h1_cmd_accept,
  input wire logic       h1_xfer_done,
  input wire logic       h1_status_valid,
  input wire logic       h1_locked_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // =====================================================================
  // Ownership
  a_lock_one_side: assert property (!(h0_locked_out && h1_locked_out))
    else $error("both hosts locked out");
  a_h0_accept_owner: assert property (h0_cmd_accept |-> !h0_locked_out)
    else $error("host 0 accepted while locked");
  a_h1_accept_owner: assert property (h1_cmd_accept |-> !h1_locked_out)
    else $error("host 1 accepted while locked");
  a_h0_status_hidden: assert property (h0_locked_out |-> !h0_status_valid)
    else $error("host 0 status valid while locked");
  a_h1_status_hidden: assert property (h1_locked_out |-> !h1_status_valid)
    else $error("host 1 status valid while locked");
  a_free_on_done: assert property ($rose(h0_xfer_done) |-> !h1_locked_out)
    else $error("host 1 still locked after release");
  a_pending_served: assert property (
    $rose(h0_xfer_done) && h1_cmd_valid |-> ##[0:2] h1_cmd_accept)
    else $error("pending host 1 command not served");
  a_free_on_h1_done: assert property ($rose(h1_xfer_done) |-> !h0_locked_out)
    else $error("host 0 still locked after release");
  a_pending_h0_served: assert property (
    $rose(h1_xfer_done) && h0_cmd_valid |-> ##[0:2] h0_cmd_accept)
    else $error("pending host 0 command not served");

  // =====================================================================
  // Flags, interrupt and status
  a_irq_has_cause: assert property (h0_irq |-> $rose(h0_seek_done) || $rose(h0_xfer_done))
    else $error("interrupt without flag");
  a_irq_one_cycle: assert property (h0_irq |=> !h0_irq)
    else $error("interrupt longer than one cycle");
  a_seek_gives_status: assert property ($rose(h0_seek_done) |-> h0_status_valid && h0_irq)
    else $error("positioning complete without status");
  a_status_kept: assert property (h0_locked_out && $past(h0_locked_out) |-> $stable(h0_status))
    else $error("host 0 status changed while locked");

  // Main scenarios reached
  c_conflict: cover property ((h0_cmd_valid && h0_locked_out) || (h1_cmd_valid && h1_locked_out));
  c_h1_done: cover property ($rose(h1_xfer_done));
  c_seek_err: cover property ($rose(h0_seek_done) && h0_status[dha_pkg::ST_LOC]);
endmodule

// ==== verif/tb_dual_host_disc_access_arbiter.sv ====
`timescale 1ns/1ps
// =====================================================================
// Two hosts share one adapter; the bench plays the disc drive
module tb_dual_host_disc_access_arbiter;
  logic clock, sys_rst, drv_cmd, drv_seek_begin, drv_seek_done, drv_xfer_done;
  logic [1:0] drv_op, drv_unit, req, wr, busy, done, err, op_q;
  logic [9:0] drv_cyl, seek_cyl, n_cmd, n_recal, n_dummy;
  logic [7:0] drv_status, rd_status;  // Drive answer, read status
  logic [1:0] unit [2];
  logic [9:0] cyl [2];
  logic [7:0] st [2];
  logic [3:0] dly, seek_errs;         // Drive delay, failing seeks left
  int failures, tests_run, cycles;
  logic got, stall;                   // Wait result, withhold positioning complete

  dha_if ch0 ();
  dha_if ch1 ();
  dha_adapter #(.TIMEOUT_CYC(200)) dha_adapter_inst (.clock(clock), .sys_rst(sys_rst),
    .h0(ch0), .h1(ch1), .drv_cmd(drv_cmd), .drv_op(drv_op), .drv_unit(drv_unit),
    .drv_cyl(drv_cyl), .drv_seek_begin(drv_seek_begin), .drv_seek_done(drv_seek_done),
    .drv_xfer_done(drv_xfer_done), .drv_status(drv_status));
  dha_host h0_inst (.clock(clock), .sys_rst(sys_rst), .bus(ch0), .usr_req(req[0]),
    .usr_write(wr[0]), .usr_drive(unit[0]), .usr_cyl(cyl[0]), .usr_busy(busy[0]),
    .usr_done(done[0]), .usr_err(err[0]), .usr_status(st[0]));
  dha_host h1_inst (.clock(clock), .sys_rst(sys_rst), .bus(ch1), .usr_req(req[1]),
    .usr_write(wr[1]), .usr_drive(unit[1]), .usr_cyl(cyl[1]), .usr_busy(busy[1]),
    .usr_done(done[1]), .usr_err(err[1]), .usr_status(st[1]));
  dha_checker dha_checker_inst (.clock(clock), .sys_rst(sys_rst),
    .h0_cmd_valid(ch0.cmd_valid), .h0_cmd_accept(ch0.cmd_accept),
    .h0_seek_done(ch0.seek_done), .h0_xfer_done(ch0.xfer_done), .h0_irq(ch0.irq),
    .h0_status(ch0.status), .h0_status_valid(ch0.status_valid),
    .h0_locked_out(ch0.locked_out), .h1_cmd_valid(ch1.cmd_valid),
    .h1_cmd_accept(ch1.cmd_accept), .h1_xfer_done(ch1.xfer_done),
    .h1_status_valid(ch1.status_valid), .h1_locked_out(ch1.locked_out));

  // Clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Drive stand-in: answers each command a few cycles later
  always @(negedge clock) begin
    // Pulses stand one cycle; seek begins some cycles after the command
    drv_seek_begin <= (dly == 4'h3) && !op_q[1];
    drv_seek_done <= (dly == 4'h1) && !op_q[1] && !stall;
    drv_xfer_done <= (dly == 4'h1) && op_q[1];
    if (drv_cmd === 1'b1) begin
      op_q <= drv_op;
      dly <= 4'h6;
      n_cmd <= n_cmd + 10'h001;
      if (drv_op == dha_pkg::OP_RECAL) n_recal <= n_recal + 10'h001;
      if (drv_op == dha_pkg::OP_READ && drv_cyl == dha_pkg::DUMMY_CYL) n_dummy <= n_dummy + 10'h001;
      if (drv_op == dha_pkg::OP_SEEK) seek_cyl <= drv_cyl;
    end else if (dly != 4'h0) begin
      dly <= dly - 4'h1;
      // Status goes out with completion; failing seeks report a location error
      if (dly == 4'h1 && op_q == dha_pkg::OP_SEEK && seek_errs != 4'h0) begin
        drv_status <= 8'h09;
        seek_errs <= seek_errs - 4'h1;
      end else if (dly == 4'h1) begin
        drv_status <= op_q[1] ? rd_status : 8'h00;
      end
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  // Compare helpers
  task automatic check1(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic check10(input logic [9:0] a, input logic [9:0] e);
    tests_run++;
    if (a !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  // One user request, one cycle long
  task automatic issue(input int h, input logic w, input logic [1:0] d, input logic [9:0] c);
    wr[h] = w;
    unit[h] = d;
    cyl[h] = c;
    req[h] = 1'b1;
    @(negedge clock);
    req[h] = 1'b0;
  endtask
  task automatic wait_done(input int h);
    int n;
    n = 0;
    while (done[h] !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    got = done[h];
  endtask

  // Host 0 alone: other side locked, seek before read
  task automatic t_single;
    issue(0, 1'b0, 2'h1, 10'h155);
    repeat (3) @(negedge clock);
    check1(ch1.locked_out, 1'b1);
    wait_done(0);
    check1(got, 1'b1);
    check1(err[0], 1'b0);
    check10(seek_cyl, 10'h155);
  endtask

  // Both ask at once: host 1 first as host 0 went last, host 0 after, status kept
  task automatic t_conflict;
    {unit[0], unit[1], cyl[0], cyl[1], wr} = {2'h1, 2'h1, 10'h011, 10'h022, 2'h0};
    req = 2'h3;
    @(negedge clock);
    req = 2'h0;
    wait_done(1);
    rd_status = 8'h03;
    check1(got, 1'b1);
    check1(busy[0], 1'b1);
    wait_done(0);
    check1(got, 1'b1);
    check10(seek_cyl, 10'h011);
    check1(err[0], 1'b1);
    check10({2'h0, ch1.status}, 10'h000);
    rd_status = 8'h00;
  endtask

  // Host 1 loses a stalled seek to the timeout of 200; waiting host 0 served
  task automatic t_timeout;
    stall = 1'b1;
    issue(1, 1'b0, 2'h3, 10'h033);
    repeat (20) @(negedge clock);
    stall = 1'b0;
    issue(0, 1'b0, 2'h3, 10'h044);
    repeat (150) @(negedge clock);
    check1(ch0.locked_out, 1'b1);
    repeat (40) @(negedge clock);
    check1(ch0.locked_out, 1'b0);
    check1(ch1.locked_out, 1'b1);
    wait_done(0);
    check1(got, 1'b1);
  endtask

  // Seek error recovery, then a drive given up
  task automatic t_seek_err;
    logic [9:0] r0, d0, c0;
    {r0, d0} = {n_recal, n_dummy};
    seek_errs = 4'h1;
    issue(0, 1'b1, 2'h1, 10'h0aa);
    wait_done(0);
    check1(err[0], 1'b0);
    check10(n_recal - r0, 10'h001);
    check10(n_dummy - d0, 10'h001);
    check10(seek_cyl, 10'h0aa);
    r0 = n_recal;
    seek_errs = 4'hf;
    issue(0, 1'b0, 2'h2, 10'h0bb);
    wait_done(0);
    check1(err[0], 1'b1);
    check10(n_recal - r0, 10'(dha_pkg::MAX_RECAL));
    repeat (20) @(negedge clock);
    seek_errs = 4'h0;
    c0 = n_cmd;
    issue(0, 1'b0, 2'h2, 10'h0bb);
    wait_done(0);
    check1(got, 1'b1);
    check10(n_cmd - c0, 10'h000);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {sys_rst, req, wr, dly, seek_errs, op_q} = {1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 2'h0};
    {stall, drv_seek_begin, drv_seek_done, drv_xfer_done} = 4'h0;
    {drv_status, rd_status, n_cmd, n_recal, n_dummy, seek_cyl} = '0;
    unit[0] = 2'h0;
    unit[1] = 2'h0;
    cyl[0] = 10'h000;
    cyl[1] = 10'h000;
    {failures, tests_run, cycles} = '0;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    t_single();
    t_conflict();
    t_seek_err();
    t_timeout();
    finish_test();
  end
endmodule
